// File: inc/eitf_defs.svh
// Constants of the external interrupt trigger and flag block.
//
// Summary of operation
// - Each of sixteen lines has a two-bit trigger field, four per byte, lowest line low.
// - Trigger code 00 low level, 01 falling, 10 rising, 11 both edges.
// - Lines 2 to 7 have enable bits in bits 7-2 of the first enable byte.
// - Lines 8 to 15 have enable bits in all bits of the second enable byte.
// - Flags of lines 2 to 15 set only while their enable bit is one.
// - Bits 1-0 of the first enable byte read zero and ignore writes.
// - A matching trigger sets the line flag; flags packed by line in two bytes.
// - Flags of lines 2 to 15 clear only when software writes zero.
// - Flags of lines 0 and 1 clear on core response or software zero.
// - Lines 2-7 and 8-15 each share one request gated by a group enable.
`ifndef EITF_DEFS_SVH
`define EITF_DEFS_SVH

`define EITF_LINES 16
`define EITF_ADDR_W 4
`define EITF_DATA_W 8
`define EITF_IST_W 4

// Register offsets.
`define EITF_OFS_TRIG0 4'h0
`define EITF_OFS_TRIG1 4'h1
`define EITF_OFS_TRIG2 4'h2
`define EITF_OFS_TRIG3 4'h3
`define EITF_OFS_EN0 4'h4
`define EITF_OFS_EN1 4'h5
`define EITF_OFS_FLG0 4'h6
`define EITF_OFS_FLG1 4'h7
`define EITF_OFS_GRP 4'h8
`define EITF_OFS_IST 4'h9
`define EITF_OFS_IMSK 4'ha

// Reset values and field layouts.
`define EITF_RST_BYTE 8'h00
`define EITF_RST_LINE 16'hffff
`define EITF_EN0_WR_MASK 8'hfc
`define EITF_GRP_MASK 8'h03
`define EITF_IST_MASK 8'h0f
`define EITF_GRP_2_7 0
`define EITF_GRP_8_15 1
`define EITF_IST_LINE0 0
`define EITF_IST_LINE1 1
`define EITF_IST_G2_7 2
`define EITF_IST_G8_15 3

`endif

// File: inc/eitf_pkg.sv
// Types of the external interrupt trigger and flag block.
`include "eitf_defs.svh"

package eitf_pkg;

    typedef logic [`EITF_DATA_W-1:0] eitf_byte_t;
    typedef logic [`EITF_ADDR_W-1:0] eitf_addr_t;
    typedef logic [`EITF_LINES-1:0] eitf_lines_t;

    typedef enum logic [1:0] {
        EITF_TRIG_LOW  = 2'h0,
        EITF_TRIG_FALL = 2'h1,
        EITF_TRIG_RISE = 2'h2,
        EITF_TRIG_BOTH = 2'h3
    } eitf_trig_t;

    typedef struct packed {
        eitf_lines_t sync_a;
        eitf_lines_t sync_b;
        eitf_lines_t prev;
    } eitf_det_state_t;

    typedef struct packed {
        logic [`EITF_LINES-1:0][1:0] trig;
        eitf_byte_t en0;
        eitf_byte_t en1;
        eitf_lines_t flag;
        logic [1:0] grp;
        logic [`EITF_IST_W-1:0] ist;
        logic [`EITF_IST_W-1:0] imsk;
        eitf_byte_t rdata;
    } eitf_state_t;

endpackage

// File: inc/eitf_det_if.sv
// Link between the register core and the line trigger detector.
`timescale 1ns/1ps
`include "eitf_defs.svh"

interface eitf_det_if;
    logic [`EITF_LINES-1:0] line;
    logic [`EITF_LINES-1:0][1:0] mode;
    logic [`EITF_LINES-1:0] hit;

    modport core (output line, output mode, input hit);
    modport det (input line, input mode, output hit);
endinterface

// File: verilog/eitf_line_detect.sv
// Synchroniser and trigger matcher for all external request lines.
`timescale 1ns/1ps
`include "eitf_defs.svh"

module eitf_line_detect (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    eitf_det_if.det det
);
    import eitf_pkg::*;

    eitf_det_state_t st_ff;
    eitf_det_state_t nxt_st;

    // ------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------
    // two-stage synchroniser
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_a = det.line;
        nxt_st.sync_b = st_ff.sync_a;
        nxt_st.prev = st_ff.sync_b;
    end

    // Lines idle high, so reset to high avoids a false rising edge.
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff.sync_a <= `EITF_RST_LINE;
            st_ff.sync_b <= `EITF_RST_LINE;
            st_ff.prev <= `EITF_RST_LINE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Trigger match
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `EITF_LINES; gi++) begin : g_line
            logic cur;
            logic old;
            assign cur = st_ff.sync_b[gi];
            assign old = st_ff.prev[gi];
            always_comb begin
                unique case (eitf_trig_t'(det.mode[gi]))
                    EITF_TRIG_LOW: det.hit[gi] = !cur;
                    EITF_TRIG_FALL: det.hit[gi] = old && !cur;
                    EITF_TRIG_RISE: det.hit[gi] = !old && cur;
                    EITF_TRIG_BOTH: det.hit[gi] = old ^ cur;
                endcase
            end
        end
    endgenerate

endmodule // eitf_line_detect

// File: verilog/eitf_top.sv
// Register core of the external interrupt trigger and flag block.
`timescale 1ns/1ps
`include "eitf_defs.svh"

module eitf_top #(
    parameter int NUM_LINES = `EITF_LINES
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire eitf_pkg::eitf_lines_t ext_line_i,
    input wire eitf_pkg::eitf_addr_t reg_addr_i,
    input wire eitf_pkg::eitf_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output eitf_pkg::eitf_byte_t reg_rdata_o,
    input wire logic ack_line0_i,
    input wire logic ack_line1_i,
    output logic req_line0_o,
    output logic req_line1_o,
    output logic req_group_2_7_o,
    output logic req_group_8_15_o,
    output logic irq_o
);
    import eitf_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NUM_LINES != `EITF_LINES) begin : g_bad_lines
        $error("eitf_top serves exactly sixteen lines");
    end

    eitf_state_t st_ff;
    eitf_state_t nxt_st;
    eitf_det_if det_bus ();

    // ------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------
    assign det_bus.line = ext_line_i;
    assign det_bus.mode = st_ff.trig;

    eitf_line_detect u_detect (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .det(det_bus.det)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic wr_at(input eitf_addr_t ofs);
        wr_at = reg_wr_i && (reg_addr_i == ofs);
    endfunction

    function automatic eitf_byte_t read_mux(input eitf_state_t s, input eitf_addr_t a);
        logic [4*`EITF_DATA_W-1:0] trig_flat;
        trig_flat = s.trig;
        unique case (a)
            `EITF_OFS_TRIG0: read_mux = trig_flat[7:0];
            `EITF_OFS_TRIG1: read_mux = trig_flat[15:8];
            `EITF_OFS_TRIG2: read_mux = trig_flat[23:16];
            `EITF_OFS_TRIG3: read_mux = trig_flat[31:24];
            `EITF_OFS_EN0: read_mux = s.en0 & `EITF_EN0_WR_MASK;
            `EITF_OFS_EN1: read_mux = s.en1;
            `EITF_OFS_FLG0: read_mux = s.flag[7:0];
            `EITF_OFS_FLG1: read_mux = s.flag[15:8];
            `EITF_OFS_GRP: read_mux = {6'h00, s.grp};
            `EITF_OFS_IST: read_mux = {4'h0, s.ist};
            `EITF_OFS_IMSK: read_mux = {4'h0, s.imsk};
            default: read_mux = `EITF_RST_BYTE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Flag and enable logic
    // ------------------------------------------------------------
    eitf_lines_t line_en;
    eitf_lines_t flag_set;
    eitf_lines_t flag_clr;
    logic [`EITF_IST_W-1:0] ist_ev;
    logic [`EITF_IST_W-1:0] ist_w1c;

    // enables of lines 2 to 7
    // enables of lines 8 to 15
    assign line_en = {st_ff.en1, st_ff.en0[7:2], 2'b11};

    assign flag_set = det_bus.hit & line_en;

    always_comb begin
        flag_clr = '0;
        if (wr_at(`EITF_OFS_FLG0)) begin
            flag_clr[7:0] = ~reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_FLG1)) begin
            flag_clr[15:8] = ~reg_wdata_i;
        end
        if (ack_line0_i) begin
            flag_clr[0] = 1'b1;
        end
        if (ack_line1_i) begin
            flag_clr[1] = 1'b1;
        end
    end

    always_comb begin
        ist_ev = '0;
        ist_ev[`EITF_IST_LINE0] = flag_set[0];
        ist_ev[`EITF_IST_LINE1] = flag_set[1];
        ist_ev[`EITF_IST_G2_7] = |flag_set[7:2];
        ist_ev[`EITF_IST_G8_15] = |flag_set[15:8];
        ist_w1c = '0;
        if (wr_at(`EITF_OFS_IST)) begin
            ist_w1c = reg_wdata_i[`EITF_IST_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (wr_at(`EITF_OFS_TRIG0)) begin
            nxt_st.trig[3:0] = reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_TRIG1)) begin
            nxt_st.trig[7:4] = reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_TRIG2)) begin
            nxt_st.trig[11:8] = reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_TRIG3)) begin
            nxt_st.trig[15:12] = reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_EN0)) begin
            nxt_st.en0 = reg_wdata_i & `EITF_EN0_WR_MASK;
        end
        if (wr_at(`EITF_OFS_EN1)) begin
            nxt_st.en1 = reg_wdata_i;
        end
        if (wr_at(`EITF_OFS_GRP)) begin
            nxt_st.grp = reg_wdata_i[1:0];
        end
        if (wr_at(`EITF_OFS_IMSK)) begin
            nxt_st.imsk = reg_wdata_i[`EITF_IST_W-1:0];
        end
        // A set in the same cycle as a clear wins.
        nxt_st.flag = (st_ff.flag & ~flag_clr) | flag_set;
        nxt_st.ist = (st_ff.ist & ~ist_w1c) | ist_ev;
        // Read data stand only in the cycle after the strobe.
        if (reg_rd_i) begin
            nxt_st.rdata = read_mux(st_ff, reg_addr_i);
        end else begin
            nxt_st.rdata = `EITF_RST_BYTE;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = st_ff.rdata;
    assign req_line0_o = st_ff.flag[0];
    assign req_line1_o = st_ff.flag[1];
    assign req_group_2_7_o = st_ff.grp[`EITF_GRP_2_7] && (|st_ff.flag[7:2]);
    assign req_group_8_15_o = st_ff.grp[`EITF_GRP_8_15] && (|st_ff.flag[15:8]);
    assign irq_o = |(st_ff.ist & st_ff.imsk);

endmodule // eitf_top

// File: test/eitf_pin_model.sv
// Model of the board pins that drive the external request lines.
`timescale 1ns/1ps
module eitf_pin_model #(
    parameter int SETTLE_NS = 5
) (
    input wire eitf_pkg::eitf_lines_t level_i,
    output eitf_pkg::eitf_lines_t ext_line_o
);
    import eitf_pkg::*;
    // Pins settle a little after the bench asks, as a board net with some load would.
    assign #(SETTLE_NS) ext_line_o = level_i;
endmodule // eitf_pin_model

// File: test/eitf_properties.sv
// Concurrent checks on the ports of the external interrupt trigger and flag block.
`timescale 1ns/1ps
module eitf_properties #(
    parameter int NUM_LINES = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire eitf_pkg::eitf_lines_t ext_line_i,
    input wire eitf_pkg::eitf_addr_t reg_addr_i,
    input wire eitf_pkg::eitf_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire eitf_pkg::eitf_byte_t reg_rdata_o,
    input wire logic ack_line0_i,
    input wire logic ack_line1_i,
    input wire logic req_line0_o,
    input wire logic req_line1_o,
    input wire logic req_group_2_7_o,
    input wire logic req_group_8_15_o,
    input wire logic irq_o
);
    import eitf_pkg::*;
    // Lines high for several samples leave no hit in flight through the synchroniser.
    logic [3:0] hi0_ff, hi1_ff, all_ff;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi0_ff <= 4'h0;
            hi1_ff <= 4'h0;
            all_ff <= 4'h0;
        end else begin
            hi0_ff <= {hi0_ff[2:0], ext_line_i[0]};
            hi1_ff <= {hi1_ff[2:0], ext_line_i[1]};
            all_ff <= {all_ff[2:0], &ext_line_i};
        end
    end
    default clocking dcb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_en0_rsv; $past(reg_rd_i) && $past(reg_addr_i) == 4'h4 |-> reg_rdata_o[1:0] == 2'b00; endproperty
    a_en0_rsv: assert property (p_en0_rsv) else $error("reserved enable bits read non zero");
    property p_ack0; ack_line0_i && ext_line_i[0] && hi0_ff == 4'hf |=> !req_line0_o; endproperty
    a_ack0: assert property (p_ack0) else $error("line 0 flag survived response");
    property p_ack1; ack_line1_i && ext_line_i[1] && hi1_ff == 4'hf |=> !req_line1_o; endproperty
    a_ack1: assert property (p_ack1) else $error("line 1 flag survived response");
    property p_hold0; req_line0_o && !ack_line0_i && !reg_wr_i |=> req_line0_o; endproperty
    a_hold0: assert property (p_hold0) else $error("line 0 flag dropped by itself");
    property p_quiet0; all_ff == 4'hf && &ext_line_i && !req_line0_o |=> !req_line0_o; endproperty
    a_quiet0: assert property (p_quiet0) else $error("line 0 flag set without event");
    property p_quiet_hi; all_ff == 4'hf && &ext_line_i && !req_group_8_15_o && !reg_wr_i |=> !req_group_8_15_o;
    endproperty
    a_quiet_hi: assert property (p_quiet_hi) else $error("upper group raised without event");
    // A write in the next cycle may clear the flags, so both cycles must be free of writes.
    property p_hold_hi;
        req_group_8_15_o && !reg_wr_i ##1 !reg_wr_i |-> req_group_8_15_o ##1 req_group_8_15_o;
    endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("upper group request dropped by itself");
    property p_fell_lo; $fell(req_group_2_7_o) |-> $past(reg_wr_i); endproperty
    a_fell_lo: assert property (p_fell_lo) else $error("lower group request fell without write");
    c_en0_read: cover property (reg_rd_i && reg_addr_i == 4'h4);
    c_ack0: cover property (ack_line0_i && req_line0_o);
    c_grp_rise: cover property ($rose(req_group_8_15_o));
endmodule // eitf_properties

bind eitf_top eitf_properties #(.NUM_LINES(NUM_LINES)) u_props (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ext_line_i(ext_line_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ack_line0_i(ack_line0_i), .ack_line1_i(ack_line1_i), .req_line0_o(req_line0_o),
    .req_line1_o(req_line1_o), .req_group_2_7_o(req_group_2_7_o), .req_group_8_15_o(req_group_8_15_o),
    .irq_o(irq_o)
);

// File: test/external_interrupt_trigger_flags_test.sv
// Self-checking bench for the external interrupt trigger and flag block.
`timescale 1ns/1ps
`include "eitf_defs.svh"
module external_interrupt_trigger_flags_test;
    import eitf_pkg::*;
    logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, ack0, ack1, req0, req1, reqa, reqb, irq;
    eitf_lines_t lines, ext_line;
    eitf_addr_t addr;
    eitf_byte_t wdata, rdata;
    int mismatches, cmp_count;
    eitf_pin_model PINS (.level_i(lines), .ext_line_o(ext_line));
    eitf_top DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ext_line_i(ext_line), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .ack_line0_i(ack0),
        .ack_line1_i(ack1), .req_line0_o(req0), .req_line1_o(req1), .req_group_2_7_o(reqa),
        .req_group_8_15_o(reqb), .irq_o(irq));
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input eitf_addr_t a, input eitf_byte_t d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input eitf_addr_t a, output eitf_byte_t d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic flags(output logic [15:0] f);
        rd(`EITF_OFS_FLG0, f[7:0]);
        rd(`EITF_OFS_FLG1, f[15:8]);
    endtask
    // Disables lines 2 to 15 around the clear so a recurring hit cannot hide it; lines 0 and 1 stay enabled.
    task automatic clear_flags(input logic [15:0] en);
        wr(`EITF_OFS_EN0, 8'h00);
        wr(`EITF_OFS_EN1, 8'h00);
        wr(`EITF_OFS_FLG0, 8'h00);
        wr(`EITF_OFS_FLG1, 8'h00);
        wr(`EITF_OFS_EN0, en[7:0]);
        wr(`EITF_OFS_EN1, en[15:8]);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    initial begin
        logic [15:0] f, en, e;
        eitf_byte_t v, w;
        eitf_trig_t m;
        {reset_n_i, reg_wr_i, reg_rd_i, ack0, ack1} = 5'h00;
        addr = 4'h0;
        wdata = 8'h00;
        lines = 16'hffff;
        mismatches = 0;
        cmp_count = 0;
        v = 8'($urandom(3));
        repeat (5) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 12; a++) begin
            rd(eitf_addr_t'(a), v);
            chk(16'(v), 16'h0000);
        end
        for (int a = 0; a < 6; a++) begin
            v = 8'($urandom);
            wr(eitf_addr_t'(a), v);
            rd(eitf_addr_t'(a), w);
            chk(16'(w), 16'((a == 4) ? (v & 8'hfc) : v));
        end
        wr(4'hb, 8'hff);
        rd(4'hb, w);
        chk(16'(w), 16'h0000);
        wr(`EITF_OFS_GRP, 8'h03);
        wr(`EITF_OFS_IMSK, 8'h0f);
        for (int k = 0; k < 4; k++) begin
            m = eitf_trig_t'(k);
            en = 16'($urandom) | 16'h0003;
            for (int a = 0; a < 4; a++) wr(eitf_addr_t'(a), {4{2'(k)}});
            clear_flags(en);
            lines <= 16'h0000;
            repeat (6) @(posedge core_clk_i);
            flags(f);
            e = (m != EITF_TRIG_RISE) ? en : 16'h0000;
            chk(f, e);
            chk(16'({reqb, reqa, req1, req0}), 16'({|e[15:8], |e[7:2], e[1:0]}));
            wr(`EITF_OFS_GRP, 8'h00);
            @(posedge core_clk_i);
            #1 chk(16'({reqb, reqa}), 16'h0000);
            wr(`EITF_OFS_GRP, 8'h03);
            clear_flags(en);
            lines <= 16'hffff;
            repeat (6) @(posedge core_clk_i);
            flags(f);
            e = (m != EITF_TRIG_FALL) ? en : 16'h0000;
            chk(f, e);
            @(posedge core_clk_i);
            {ack0, ack1} <= 2'b11;
            @(posedge core_clk_i);
            {ack0, ack1} <= 2'b00;
            @(posedge core_clk_i);
            #1 chk(16'({req1, req0}), 16'h0000);
            flags(f);
            chk(f, e & 16'hfffc);
            wr(`EITF_OFS_IMSK, 8'h00);
            @(posedge core_clk_i);
            #1 chk(16'(irq), 16'h0000);
            wr(`EITF_OFS_IMSK, 8'h0f);
            @(posedge core_clk_i);
            #1 chk(16'(irq), 16'h0001);
            wr(`EITF_OFS_IST, 8'h0f);
            @(posedge core_clk_i);
            #1 chk(16'(irq), 16'h0000);
        end
        give_verdict();
    end
endmodule // external_interrupt_trigger_flags_test
